// *** design/mti_mag_threshold_irq_unit.sv ***
/*
 contents: top of the magnetic threshold interrupt unit: register file,
 sample and temperature holding, source flags, pin driver and comparator.
 assumptions: the serial port logic presents one register access per cycle on
 the reg_ port, on clk; measurement results arrive as one-cycle valid pulses.
*/
`timescale 1ns/1ps
`include "mti_defines.svh"
module mti_mag_threshold_irq_unit (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic mag_valid,
	input wire logic [15:0] mag_x,
	input wire logic [15:0] mag_y,
	input wire logic [15:0] mag_z,
	input wire logic mag_range_overflow,
	input wire logic temp_valid,
	input wire logic [15:0] temp_value,
	output logic magnetic_irq_pin
);
	mti_link_if lnk ();

	// configuration and limit
	mti_pkg::mti_cfg_t cfg_r;
	mti_pkg::mti_cfg_t cfg_nxt;
	logic [14:0] limit_r;
	logic [14:0] limit_nxt;

	// measurement holding
	mti_pkg::mti_sample_t x_r;
	mti_pkg::mti_sample_t x_nxt;
	mti_pkg::mti_sample_t y_r;
	mti_pkg::mti_sample_t y_nxt;
	mti_pkg::mti_sample_t z_r;
	mti_pkg::mti_sample_t z_nxt;
	logic [15:0] temp_r;
	logic [15:0] temp_nxt;
	logic ovf_pend_r;
	logic ovf_pend_nxt;

	// source flags
	mti_pkg::mti_axes_t pos_flag_r;
	mti_pkg::mti_axes_t pos_flag_nxt;
	mti_pkg::mti_axes_t neg_flag_r;
	mti_pkg::mti_axes_t neg_flag_nxt;
	logic ovf_flag_r;
	logic ovf_flag_nxt;
	logic event_r;
	logic event_nxt;

	// read path
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;

	logic src_read;
	mti_pkg::mti_axes_t axis_en;
	mti_pkg::mti_axes_t pos_new;
	mti_pkg::mti_axes_t neg_new;
	logic ovf_new;
	logic new_event;

	function automatic logic hit_addr(input logic [7:0] a, input logic [7:0] off);
		hit_addr = (a == off);
	endfunction

	assign src_read = reg_rd && hit_addr(reg_addr, `MTI_OFF_IRQ_SOURCE);
	assign axis_en = {cfg_r.x_axis_irq_enable, cfg_r.y_axis_irq_enable,
		cfg_r.z_axis_irq_enable};

	// write side of configuration and limit
	always_comb begin
		cfg_nxt = cfg_r;
		limit_nxt = limit_r;
		if (reg_wr) begin
			if (hit_addr(reg_addr, `MTI_OFF_IRQ_CONFIG)) begin
				// reserved bits stored as written; the host keeps them at 0 and 1
				cfg_nxt = mti_pkg::mti_cfg_t'(reg_wdata);
			end
			if (hit_addr(reg_addr, `MTI_OFF_THR_LOW)) begin
				limit_nxt[7:0] = reg_wdata;
			end
			if (hit_addr(reg_addr, `MTI_OFF_THR_HIGH)) begin
				// top bit dropped; host must write it as zero
				limit_nxt[14:8] = reg_wdata[6:0];
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cfg_r <= mti_pkg::mti_cfg_t'(`MTI_CFG_RESET);
			limit_r <= `MTI_THR_RESET;
		end else begin
			cfg_r <= cfg_nxt;
			limit_r <= limit_nxt;
		end
	end

	// measurement holding: samples, temperature, overflow of the current set
	always_comb begin
		x_nxt = x_r;
		y_nxt = y_r;
		z_nxt = z_r;
		temp_nxt = temp_r;
		ovf_pend_nxt = ovf_pend_r;
		if (mag_valid) begin
			x_nxt = mti_pkg::mti_sample_t'(mag_x);
			y_nxt = mti_pkg::mti_sample_t'(mag_y);
			z_nxt = mti_pkg::mti_sample_t'(mag_z);
			ovf_pend_nxt = mag_range_overflow;
		end
		if (temp_valid) begin
			temp_nxt = temp_value;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			x_r <= 16'h0000;
			y_r <= 16'h0000;
			z_r <= 16'h0000;
			temp_r <= 16'h0000;
			ovf_pend_r <= 1'b0;
		end else begin
			x_r <= x_nxt;
			y_r <= y_nxt;
			z_r <= z_nxt;
			temp_r <= temp_nxt;
			ovf_pend_r <= ovf_pend_nxt;
		end
	end

	// comparator sees the held set one cycle after capture
	logic cmp_go_r;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cmp_go_r <= 1'b0;
		end else begin
			cmp_go_r <= mag_valid;
		end
	end

	assign lnk.x_sample = x_r;
	assign lnk.y_sample = y_r;
	assign lnk.z_sample = z_r;
	assign lnk.magnitude_limit = limit_r;
	assign lnk.sample_valid = cmp_go_r;

	mti_axis_cmp u_cmp (
		.clk(clk),
		.reset_n(reset_n),
		.lnk(lnk.cmp_side)
	);

	// new hits of this result, masked per axis
	always_comb begin
		pos_new = 3'h0;
		neg_new = 3'h0;
		ovf_new = 1'b0;
		if (lnk.hit_valid) begin
			pos_new = lnk.pos_hit & axis_en;
			neg_new = lnk.neg_hit & axis_en;
			ovf_new = ovf_pend_r && cfg_r.pin_irq_enable;
		end
		new_event = (|pos_new) || (|neg_new) || ovf_new;
	end

	// source flags: latched mode accumulates, unlatched mode tracks each result
	always_comb begin
		pos_flag_nxt = pos_flag_r;
		neg_flag_nxt = neg_flag_r;
		ovf_flag_nxt = ovf_flag_r;
		event_nxt = event_r;
		if (src_read) begin
			pos_flag_nxt = 3'h0;
			neg_flag_nxt = 3'h0;
			ovf_flag_nxt = 1'b0;
			event_nxt = 1'b0;
		end
		if (lnk.hit_valid && cfg_r.latch_disable) begin
			// a quiet result clears the flags so the pin can drop
			pos_flag_nxt = pos_new;
			neg_flag_nxt = neg_new;
			ovf_flag_nxt = ovf_new;
			event_nxt = new_event;
		end else if (lnk.hit_valid) begin
			// setting wins over a read in the same cycle
			pos_flag_nxt = pos_flag_nxt | pos_new;
			neg_flag_nxt = neg_flag_nxt | neg_new;
			ovf_flag_nxt = ovf_flag_nxt | ovf_new;
			event_nxt = event_nxt | new_event;
		end
		if (!cfg_r.pin_irq_enable) begin
			ovf_flag_nxt = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pos_flag_r <= 3'h0;
			neg_flag_r <= 3'h0;
			ovf_flag_r <= 1'b0;
			event_r <= 1'b0;
		end else begin
			pos_flag_r <= pos_flag_nxt;
			neg_flag_r <= neg_flag_nxt;
			ovf_flag_r <= ovf_flag_nxt;
			event_r <= event_nxt;
		end
	end

	// pin driver follows the flag state; latched hold lives in the driver
	assign lnk.pin_req = event_r && cfg_r.pin_irq_enable;
	assign lnk.pin_evt = new_event && cfg_r.pin_irq_enable;
	assign lnk.src_read = src_read;
	assign lnk.pin_irq_enable = cfg_r.pin_irq_enable;
	assign lnk.pin_polarity_high = cfg_r.pin_polarity_high;
	assign lnk.latch_disable = cfg_r.latch_disable;

	mti_pin_drv u_pin (
		.clk(clk),
		.reset_n(reset_n),
		.lnk(lnk.pin_side),
		.magnetic_irq_pin(magnetic_irq_pin)
	);

	// read path; returns the pre-clear source value on a source read
	always_comb begin
		rdata_nxt = rdata_r;
		if (reg_rd) begin
			case (reg_addr)
				`MTI_OFF_X_LOW: rdata_nxt = x_r[7:0];
				`MTI_OFF_X_HIGH: rdata_nxt = x_r[15:8];
				`MTI_OFF_Y_LOW: rdata_nxt = y_r[7:0];
				`MTI_OFF_Y_HIGH: rdata_nxt = y_r[15:8];
				`MTI_OFF_Z_LOW: rdata_nxt = z_r[7:0];
				`MTI_OFF_Z_HIGH: rdata_nxt = z_r[15:8];
				`MTI_OFF_TEMP_LOW: rdata_nxt = temp_r[7:0];
				`MTI_OFF_TEMP_HIGH: rdata_nxt = temp_r[15:8];
				`MTI_OFF_IRQ_CONFIG: rdata_nxt = cfg_r;
				`MTI_OFF_IRQ_SOURCE: rdata_nxt = {pos_flag_r, neg_flag_r, ovf_flag_r, event_r};
				`MTI_OFF_THR_LOW: rdata_nxt = limit_r[7:0];
				`MTI_OFF_THR_HIGH: rdata_nxt = {1'b0, limit_r[14:8]};
				default: rdata_nxt = `MTI_BYTE_RESET;
			endcase
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rdata_r <= `MTI_BYTE_RESET;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	assign reg_rdata = rdata_r;
endmodule

// *** design/mti_defines.svh ***
/*
 contents: register offsets, field positions and reset values of the
 magnetic threshold interrupt unit.
 assumptions: included by bare name from every design file that needs it.
*/
`ifndef MTI_DEFINES_SVH
`define MTI_DEFINES_SVH

`define MTI_ADDR_W 8
`define MTI_DATA_W 8
`define MTI_SAMPLE_W 16
`define MTI_THR_W 15

`define MTI_OFF_X_LOW 8'h28
`define MTI_OFF_X_HIGH 8'h29
`define MTI_OFF_Y_LOW 8'h2a
`define MTI_OFF_Y_HIGH 8'h2b
`define MTI_OFF_Z_LOW 8'h2c
`define MTI_OFF_Z_HIGH 8'h2d
`define MTI_OFF_TEMP_LOW 8'h2e
`define MTI_OFF_TEMP_HIGH 8'h2f
`define MTI_OFF_IRQ_CONFIG 8'h30
`define MTI_OFF_IRQ_SOURCE 8'h31
`define MTI_OFF_THR_LOW 8'h32
`define MTI_OFF_THR_HIGH 8'h33

`define MTI_CFG_X_EN 7
`define MTI_CFG_Y_EN 6
`define MTI_CFG_Z_EN 5
`define MTI_CFG_POL 2
`define MTI_CFG_LATCH_DIS 1
`define MTI_CFG_PIN_EN 0
`define MTI_CFG_RESET 8'h08

`define MTI_SRC_POS_X 7
`define MTI_SRC_NEG_X 4
`define MTI_SRC_OVF 1
`define MTI_SRC_EVENT 0

`define MTI_THR_RESET 15'h0000
`define MTI_BYTE_RESET 8'h00

`endif

// *** design/mti_pkg.sv ***
/*
 contents: shared types of the magnetic threshold interrupt unit.
 assumptions: compiled before the interface and all modules.
*/
package mti_pkg;
	typedef logic signed [15:0] mti_sample_t;
	typedef logic [2:0] mti_axes_t;
	typedef struct packed {
		logic x_axis_irq_enable;
		logic y_axis_irq_enable;
		logic z_axis_irq_enable;
		logic rsvd_one_low;
		logic rsvd_one_high;
		logic pin_polarity_high;
		logic latch_disable;
		logic pin_irq_enable;
	} mti_cfg_t;
endpackage

// *** design/mti_link_if.sv ***
/*
 contents: carrier between the unit top, the axis comparator and the pin driver.
 assumptions: all signals on the one clk of the top module.
*/
`timescale 1ns/1ps
interface mti_link_if;
	mti_pkg::mti_sample_t x_sample;
	mti_pkg::mti_sample_t y_sample;
	mti_pkg::mti_sample_t z_sample;
	logic [14:0] magnitude_limit;
	logic sample_valid;
	mti_pkg::mti_axes_t pos_hit;
	mti_pkg::mti_axes_t neg_hit;
	logic hit_valid;
	logic pin_req;
	logic pin_evt;
	logic src_read;
	logic pin_irq_enable;
	logic pin_polarity_high;
	logic latch_disable;
	modport top_side (output x_sample, y_sample, z_sample, magnitude_limit, sample_valid,
		input pos_hit, neg_hit, hit_valid,
		output pin_req, pin_evt, src_read, pin_irq_enable, pin_polarity_high, latch_disable);
	modport cmp_side (input x_sample, y_sample, z_sample, magnitude_limit, sample_valid,
		output pos_hit, neg_hit, hit_valid);
	modport pin_side (input pin_req, pin_evt, src_read, pin_irq_enable, pin_polarity_high,
		latch_disable);
endinterface

// *** design/mti_axis_cmp.sv ***
/*
 contents: per-axis signed comparison of a sample set against the magnitude limit.
 assumptions: samples and limit stable in the cycle sample_valid is high.
*/
`timescale 1ns/1ps
module mti_axis_cmp (
	input wire logic clk,
	input wire logic reset_n,
	mti_link_if.cmp_side lnk
);
	mti_pkg::mti_axes_t pos_r;
	mti_pkg::mti_axes_t pos_nxt;
	mti_pkg::mti_axes_t neg_r;
	mti_pkg::mti_axes_t neg_nxt;
	logic valid_r;
	logic valid_nxt;

	// 17-bit signed compare so the negated limit never wraps
	function automatic logic above_pos(input mti_pkg::mti_sample_t s, input logic [14:0] lim);
		above_pos = 17'($signed(s)) > $signed({2'b00, lim});
	endfunction

	function automatic logic below_neg(input mti_pkg::mti_sample_t s, input logic [14:0] lim);
		below_neg = 17'($signed(s)) < -$signed({2'b00, lim});
	endfunction

	always_comb begin
		pos_nxt = pos_r;
		neg_nxt = neg_r;
		valid_nxt = lnk.sample_valid;
		if (lnk.sample_valid) begin
			pos_nxt = {above_pos(lnk.x_sample, lnk.magnitude_limit),
				above_pos(lnk.y_sample, lnk.magnitude_limit),
				above_pos(lnk.z_sample, lnk.magnitude_limit)};
			neg_nxt = {below_neg(lnk.x_sample, lnk.magnitude_limit),
				below_neg(lnk.y_sample, lnk.magnitude_limit),
				below_neg(lnk.z_sample, lnk.magnitude_limit)};
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pos_r <= 3'h0;
			neg_r <= 3'h0;
			valid_r <= 1'b0;
		end else begin
			pos_r <= pos_nxt;
			neg_r <= neg_nxt;
			valid_r <= valid_nxt;
		end
	end

	assign lnk.pos_hit = pos_r;
	assign lnk.neg_hit = neg_r;
	assign lnk.hit_valid = valid_r;
endmodule

// *** design/mti_pin_drv.sv ***
/*
 contents: drive of the magnetic interrupt pin with polarity and latching.
 assumptions: pin_evt is a one-cycle pulse, pin_req a level, same clock.
*/
`timescale 1ns/1ps
module mti_pin_drv (
	input wire logic clk,
	input wire logic reset_n,
	mti_link_if.pin_side lnk,
	output logic magnetic_irq_pin
);
	logic asserted_r;
	logic asserted_nxt;
	logic pin_r;
	logic pin_nxt;

	always_comb begin
		asserted_nxt = asserted_r;
		if (!lnk.pin_irq_enable) begin
			asserted_nxt = 1'b0;
		end else if (lnk.latch_disable) begin
			asserted_nxt = lnk.pin_req;
		end else if (lnk.pin_evt) begin
			asserted_nxt = 1'b1; // set beats a coincident source read
		end else if (lnk.src_read) begin
			asserted_nxt = 1'b0;
		end
		pin_nxt = lnk.pin_polarity_high ? asserted_nxt : ~asserted_nxt;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			asserted_r <= 1'b0;
			pin_r <= 1'b1;
		end else begin
			asserted_r <= asserted_nxt;
			pin_r <= pin_nxt;
		end
	end

	assign magnetic_irq_pin = pin_r;
endmodule

// *** test/mti_host_model.sv ***
/* host side of the register port: one access at a time.
 assumes the unit samples strobes on the rising clk edge. */
`timescale 1ns/1ps
module mti_host_model (
	input wire logic clk,
	output logic [7:0] reg_addr,
	output logic reg_wr,
	output logic reg_rd,
	output logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata
);
	initial begin
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 8'h00;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		logic [7:0] w;
		w = v;
		if (a == 8'h30)
			w[4:3] = 2'h1;
		if (a == 8'h33)
			w[7] = 1'b0;
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= w;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		// data lines no longer valid, so show garbage
		reg_wdata <= ~w;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		v = reg_rdata;
	endtask
endmodule

// *** test/mti_properties.sv ***
/* port checker of the threshold unit top.
 assumes the register map and sample latency of the top. */
`timescale 1ns/1ps
module mti_props (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic mag_valid,
	input wire logic [15:0] mag_x,
	input wire logic [15:0] mag_y,
	input wire logic [15:0] mag_z,
	input wire logic mag_range_overflow,
	input wire logic temp_valid,
	input wire logic [15:0] temp_value,
	input wire logic magnetic_irq_pin
);
	logic [7:0] cfg_r, cfg_nxt;
	logic [14:0] lim_r, lim_nxt;
	logic [2:0] cnt_r, cnt_nxt;
	logic [4:0] mvh_r, mvh_nxt;
	logic rd31, hit, quiet, act, stab, mvs;
	// limit passed in, so the assign below wakes on limit writes too
	function automatic logic ax(input logic [15:0] s, input logic [14:0] lim);
		logic signed [16:0] v, l;
		v = {s[15], s};
		l = {2'h0, lim};
		ax = v > l || v < -l;
	endfunction
	// shadow of config and limit, taken from the write strobes
	always_comb begin
		cfg_nxt = cfg_r;
		lim_nxt = lim_r;
		mvh_nxt = {mvh_r[3:0], mag_valid};
		cnt_nxt = (cnt_r == 3'h7) ? cnt_r : cnt_r + 3'h1;
		if (reg_wr && reg_addr == 8'h30)
			cfg_nxt = reg_wdata;
		if (reg_wr && reg_addr == 8'h32)
			lim_nxt[7:0] = reg_wdata;
		if (reg_wr && reg_addr == 8'h33)
			lim_nxt[14:8] = reg_wdata[6:0];
		if (reg_wr && reg_addr[7:2] == 6'h0c)
			cnt_nxt = 3'h0;
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cfg_r <= 8'h08;
			lim_r <= 15'h0000;
			cnt_r <= 3'h0;
			mvh_r <= 5'h00;
		end else begin
			cfg_r <= cfg_nxt;
			lim_r <= lim_nxt;
			cnt_r <= cnt_nxt;
			mvh_r <= mvh_nxt;
		end
	end
	assign rd31 = reg_rd && reg_addr == 8'h31;
	assign act = magnetic_irq_pin == cfg_r[2];
	// settled: no config, source or limit write lately, so the shadow is trusted
	assign stab = cnt_r >= 3'h4;
	assign mvs = mag_valid && stab;
	assign hit = (cfg_r[7] && ax(mag_x, lim_r)) || (cfg_r[6] && ax(mag_y, lim_r)) ||
		(cfg_r[5] && ax(mag_z, lim_r));
	assign quiet = !hit && !mag_range_overflow;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);
	chk_limit_top: assert property (reg_rd && reg_addr == 8'h33 |=> !reg_rdata[7])
		else $error("limit high byte bit7 set");
	chk_pin_off: assert property (stab && !cfg_r[0] |-> !act)
		else $error("pin active while disabled");
	chk_cross_pin: assert property (mvs && hit && cfg_r[0] |-> ##4 act)
		else $error("crossing did not assert pin");
	chk_ovf_pin: assert property (mvs && mag_range_overflow && cfg_r[0] |-> ##4 act)
		else $error("overflow did not assert pin");
	chk_unlatch_rel: assert property (mvs && quiet && cfg_r[1] |-> ##4 !act)
		else $error("unlatched pin not released");
	chk_latch_hold: assert property (!cfg_r[1] && stab && act && !rd31 && !$past(rd31) |=> act)
		else $error("latched pin dropped");
	chk_src_clear: assert property (rd31 ##2 (rd31 && mvh_r == 5'h00 && !mag_valid)
		|=> reg_rdata == 8'h00) else $error("source not cleared by read");
	chk_event_sum: assert property (rd31 |=> reg_rdata[0] == |reg_rdata[7:1])
		else $error("event bit disagrees with flags");
	cov_cross: cover property (mvs && hit && cfg_r[0]);
	cov_src_back: cover property (rd31 ##2 rd31);
	cov_pin_act: cover property (stab && act && cfg_r[0]);
endmodule
bind mti_mag_threshold_irq_unit mti_props u_props (.clk(clk), .reset_n(reset_n),
	.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
	.reg_rdata(reg_rdata), .mag_valid(mag_valid), .mag_x(mag_x), .mag_y(mag_y),
	.mag_z(mag_z), .mag_range_overflow(mag_range_overflow), .temp_valid(temp_valid),
	.temp_value(temp_value), .magnetic_irq_pin(magnetic_irq_pin));

// *** test/tb_top.sv ***
/* self-checking bench of the threshold unit.
 assumes the host model drives the register port. */
`timescale 1ns/1ps
module tb_top;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic mag_valid = 1'b0;
	logic mag_range_overflow = 1'b0;
	logic temp_valid = 1'b0;
	logic [15:0] mag_x = 16'h0000, mag_y = 16'h0000, mag_z = 16'h0000;
	logic [15:0] temp_value = 16'h0000;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
	logic reg_wr, reg_rd, magnetic_irq_pin;
	int failures = 0;
	int samples_checked = 0;
	int cyc = 0;
	initial forever #12.5 clk = ~clk;
	mti_host_model host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
	mti_mag_threshold_irq_unit dut (.clk(clk), .reset_n(reset_n),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .mag_valid(mag_valid), .mag_x(mag_x), .mag_y(mag_y),
		.mag_z(mag_z), .mag_range_overflow(mag_range_overflow), .temp_valid(temp_valid),
		.temp_value(temp_value), .magnetic_irq_pin(magnetic_irq_pin));
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		samples_checked++;
		if (g !== e) begin
			failures++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		host.rd(a, d);
		chk($sformatf("reg %h", a), e, d);
	endtask
	task automatic pin(input logic e);
		@(negedge clk);
		chk("pin", {7'h00, e}, {7'h00, magnetic_irq_pin});
	endtask
	// settle any config write first so the sample meets a stable setup
	task automatic smp(input logic [15:0] x, input logic [15:0] y, input logic [15:0] z,
		input logic o);
		repeat (5) @(posedge clk);
		mag_valid <= 1'b1;
		mag_x <= x;
		mag_y <= y;
		mag_z <= z;
		mag_range_overflow <= o;
		@(posedge clk);
		mag_valid <= 1'b0;
		repeat (4) @(posedge clk);
	endtask
	task automatic end_sim;
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			failures++;
			end_sim;
		end
	end
	initial begin
		repeat (6) @(posedge clk);
		reset_n <= 1'b1;
		pin(1'b1);
		rchk(8'h30, 8'h08);
		rchk(8'h31, 8'h00);
		rchk(8'h32, 8'h00);
		rchk(8'h33, 8'h00);
		rchk(8'h40, 8'h00);
		@(posedge clk);
		temp_valid <= 1'b1;
		temp_value <= 16'hff9c;
		@(posedge clk);
		temp_valid <= 1'b0;
		rchk(8'h2e, 8'h9c);
		rchk(8'h2f, 8'hff);
		host.wr(8'h33, 8'h01);
		host.wr(8'h32, 8'h00);
		rchk(8'h33, 8'h01);
		host.wr(8'h30, 8'he9);
		smp(16'h0101, 16'hfeff, 16'h0100, 1'b0);
		pin(1'b0);
		rchk(8'h28, 8'h01);
		rchk(8'h2b, 8'hfe);
		smp(16'h0000, 16'h0000, 16'h0000, 1'b0);
		pin(1'b0);
		rchk(8'h31, 8'h89);
		rchk(8'h31, 8'h00);
		pin(1'b1);
		host.wr(8'h30, 8'hc9);
		smp(16'hff00, 16'h0000, 16'h7fff, 1'b0);
		rchk(8'h31, 8'h00);
		smp(16'h0000, 16'h0000, 16'h0000, 1'b1);
		rchk(8'h31, 8'h03);
		host.wr(8'h30, 8'he8);
		smp(16'h0200, 16'h0000, 16'h0000, 1'b1);
		pin(1'b1);
		rchk(8'h31, 8'h81);
		host.wr(8'h30, 8'hef);
		rchk(8'h30, 8'hef);
		smp(16'h0000, 16'h0000, 16'hfe00, 1'b0);
		pin(1'b1);
		smp(16'h0000, 16'h0000, 16'h0000, 1'b0);
		pin(1'b0);
		end_sim;
	end
endmodule
